// *** rtl/acc_alu_pkg.sv ***
// Shared constants and carriers for the accumulator execute slice.
// Assumes one instruction is presented per four-phase instruction cycle.
package acc_alu_pkg;
    // Opcode fields
    localparam logic [7:0] OP_ADD_LIT = 8'h0f;
    localparam logic [7:0] OP_AND_LIT = 8'h0b;
    localparam logic [5:0] OP_ADD_FILE = 6'h09;
    localparam logic [5:0] OP_ADD_FILE_C = 6'h08;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    // Indexed literal offset window top
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    // Access bank split: offsets below 0x60 map to bank 0, the rest to bank 15
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;

    // Four phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } phase_e;

    typedef enum logic [2:0] {
        OPK_NONE = 3'b000,
        OPK_ADD_LIT = 3'b001,
        OPK_AND_LIT = 3'b010,
        OPK_ADD_FILE = 3'b011,
        OPK_ADD_FILE_C = 3'b100
    } opkind_e;

    // Status flags
    typedef struct packed {
        logic negative;
        logic signed_wrap_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } flags_s;

    localparam flags_s FLAGS_RESET = '0;

    // File register write request
    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] data;
    } file_wr_s;
endpackage

// *** rtl/add_and_accumulator_ops.sv ***
// Execute slice for literal add, file add, add with carry and literal AND.
// Assumes the data memory returns FILE_RDATA combinationally for FILE_ADDR
// during the read phase, and the fetch unit holds INSTR for a whole cycle.
// How it works
// - Opcode 0x0f with a literal adds the literal into the accumulator.
// - All three adds refresh negative, wrap, carry, half-carry and zero.
// - Upper six bits 001001 add the accumulator to the file register.
// - Destination bit 0 writes the accumulator, 1 the file register.
// - Access bit 0 uses the access bank, 1 joins the bank select value.
// - Extended set, access 0 and operand up to 0x5f uses indexed mode.
// - Upper six bits 001000 add accumulator, file register and carry.
// - Opcode 0x0b with a literal ANDs the literal into the accumulator.
// - The literal AND touches only negative and zero flags.
// - Each instruction is one word done in decode, read, process, write.
module add_and_accumulator_ops (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR,
    input wire logic EXT_SET_EN,
    input wire logic [3:0] BANK_SELECT,
    input wire logic [11:0] INDEX_BASE,
    input wire logic [7:0] FILE_RDATA,
    output logic [11:0] FILE_ADDR,
    output acc_alu_pkg::file_wr_s FILE_WR,
    output logic [7:0] ACC,
    output acc_alu_pkg::flags_s FLAGS,
    output logic [1:0] PHASE,
    output logic DONE,
    output logic INDEXED_MODE
);

    // Result of an 8-bit add: half carry, carry out and sum
    function automatic logic [9:0] add8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic ci);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        add8 = {low[4], full};
    endfunction

    // Flags after an add
    function automatic acc_alu_pkg::flags_s add_flags(input logic [7:0] a,
                                                      input logic [7:0] b,
                                                      input logic [9:0] r);
        acc_alu_pkg::flags_s f;
        f.negative = r[7];
        f.zero = (r[7:0] == 8'h00);
        f.carry = r[8];
        f.half_carry_flag = r[9];
        f.signed_wrap_flag = (a[7] == b[7]) && (r[7] != a[7]);
        add_flags = f;
    endfunction

    // True for the two kinds that take their operand from a file register
    function automatic logic is_file_kind(input acc_alu_pkg::opkind_e k);
        is_file_kind = (k == acc_alu_pkg::OPK_ADD_FILE) ||
                       (k == acc_alu_pkg::OPK_ADD_FILE_C);
    endfunction

    // Opcode decode of one instruction word
    function automatic acc_alu_pkg::opkind_e decode_kind(
        input logic [15:0] w
    );
        acc_alu_pkg::opkind_e k;
        if (w[15:8] == acc_alu_pkg::OP_ADD_LIT) begin
            k = acc_alu_pkg::OPK_ADD_LIT;
        end else if (w[15:8] == acc_alu_pkg::OP_AND_LIT) begin
            k = acc_alu_pkg::OPK_AND_LIT;
        end else if (w[15:10] == acc_alu_pkg::OP_ADD_FILE) begin
            k = acc_alu_pkg::OPK_ADD_FILE;
        end else if (w[15:10] == acc_alu_pkg::OP_ADD_FILE_C) begin
            k = acc_alu_pkg::OPK_ADD_FILE_C;
        end else begin
            k = acc_alu_pkg::OPK_NONE; // Unknown words run as no-ops
        end
        decode_kind = k;
    endfunction

    // Operand address with the indexed flag on top
    // Literal kinds form an address too; nothing reads it for them.
    function automatic logic [12:0] form_addr(input logic [15:0] w,
                                              input logic ext,
                                              input logic [3:0] bank,
                                              input logic [11:0] base);
        logic [7:0] f;
        logic [11:0] a;
        logic ix;
        f = w[7:0];
        a = 12'h000;
        ix = 1'b0;
        if (w[acc_alu_pkg::ACCESS_BIT]) begin
            a = {bank, f};
        end else if (ext && f <= acc_alu_pkg::INDEXED_MAX) begin
            a = base + {4'h0, f};
            ix = 1'b1;
        end else if (f < acc_alu_pkg::ACCESS_SPLIT) begin
            a = {acc_alu_pkg::BANK_RESET, f};
        end else begin
            a = {acc_alu_pkg::ACCESS_HIGH_BANK, f};
        end
        form_addr = {ix, a};
    endfunction

    // Sequencer state
    acc_alu_pkg::phase_e phase, next_phase;
    acc_alu_pkg::opkind_e kind, next_kind;
    logic [15:0] ir, next_ir;
    logic [11:0] addr, next_addr;
    logic indexed, next_indexed;

    // Datapath state
    logic [7:0] operand, next_operand;
    logic [7:0] acc, next_acc;
    logic [7:0] result, next_result;
    acc_alu_pkg::flags_s flags, next_flags;
    acc_alu_pkg::flags_s res_flags, next_res_flags;
    acc_alu_pkg::file_wr_s wr, next_wr;
    logic done, next_done;

    // Phase walk, instruction capture and operand address
    // The address is held from decode to the next take, so the
    // memory sees a steady address through the read phase.
    always_comb begin
        next_phase = phase;
        next_kind = kind;
        next_ir = ir;
        next_addr = addr;
        next_indexed = indexed;
        case (phase)
            acc_alu_pkg::PH_DECODE: begin
                if (INSTR_VALID) begin
                    next_ir = INSTR;
                    next_kind = decode_kind(INSTR);
                    {next_indexed, next_addr} = form_addr(INSTR, EXT_SET_EN,
                                                          BANK_SELECT,
                                                          INDEX_BASE);
                    next_phase = acc_alu_pkg::PH_READ;
                end
            end
            acc_alu_pkg::PH_READ: begin
                next_phase = acc_alu_pkg::PH_PROCESS;
            end
            acc_alu_pkg::PH_PROCESS: begin
                next_phase = acc_alu_pkg::PH_WRITE;
            end
            acc_alu_pkg::PH_WRITE: begin
                next_phase = acc_alu_pkg::PH_DECODE;
            end
            default: begin
                next_phase = acc_alu_pkg::PH_DECODE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            phase <= acc_alu_pkg::PH_DECODE;
            kind <= acc_alu_pkg::OPK_NONE;
            ir <= 16'h0000;
            addr <= 12'h000;
            indexed <= 1'b0;
        end else begin
            phase <= next_phase;
            kind <= next_kind;
            ir <= next_ir;
            addr <= next_addr;
            indexed <= next_indexed;
        end
    end

    // Operand fetch, arithmetic and destination write
    // Flags are staged in res_flags and only land in the write phase,
    // so the carry-in of a carry add is the carry from before it.
    always_comb begin
        logic [9:0] sum;
        sum = '0;
        next_operand = operand;
        next_acc = acc;
        next_result = result;
        next_flags = flags;
        next_res_flags = res_flags;
        next_wr = '0;
        next_done = 1'b0;
        case (phase)
            acc_alu_pkg::PH_READ: begin
                // Literal or file register operand
                if (is_file_kind(kind)) begin
                    next_operand = FILE_RDATA;
                end else begin
                    next_operand = ir[7:0];
                end
            end
            acc_alu_pkg::PH_PROCESS: begin
                next_res_flags = flags;
                case (kind)
                    acc_alu_pkg::OPK_ADD_LIT,
                    acc_alu_pkg::OPK_ADD_FILE: begin
                        sum = add8(acc, operand, 1'b0);
                        next_result = sum[7:0];
                        next_res_flags = add_flags(acc, operand, sum);
                    end
                    acc_alu_pkg::OPK_ADD_FILE_C: begin
                        sum = add8(acc, operand, flags.carry);
                        next_result = sum[7:0];
                        next_res_flags = add_flags(acc, operand, sum);
                    end
                    acc_alu_pkg::OPK_AND_LIT: begin
                        next_result = acc & operand;
                        next_res_flags.negative = next_result[7];
                        next_res_flags.zero = (next_result == 8'h00);
                    end
                    default: begin
                        next_result = acc;
                    end
                endcase
            end
            acc_alu_pkg::PH_WRITE: begin
                if (kind != acc_alu_pkg::OPK_NONE) begin
                    next_flags = res_flags;
                    next_done = 1'b1;
                    if (is_file_kind(kind) && ir[acc_alu_pkg::DEST_BIT]) begin
                        next_wr.we = 1'b1;
                        next_wr.addr = addr;
                        next_wr.data = result;
                    end else begin
                        next_acc = result;
                    end
                end
            end
            default: begin
                // Decode phase holds the datapath still
                next_wr = '0;
            end
        endcase
    end

    // Datapath registers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            operand <= 8'h00;
            acc <= acc_alu_pkg::ACC_RESET;
            result <= 8'h00;
            flags <= acc_alu_pkg::FLAGS_RESET;
            res_flags <= acc_alu_pkg::FLAGS_RESET;
            wr <= '0;
            done <= 1'b0;
        end else begin
            operand <= next_operand;
            acc <= next_acc;
            result <= next_result;
            flags <= next_flags;
            res_flags <= next_res_flags;
            wr <= next_wr;
            done <= next_done;
        end
    end

    // Outputs straight from flip-flops
    assign FILE_ADDR = addr;
    assign FILE_WR = wr;
    assign ACC = acc;
    assign FLAGS = flags;
    assign PHASE = phase;
    assign DONE = done;
    assign INDEXED_MODE = indexed;
endmodule

// *** testbench/add_and_accumulator_ops_properties.sv ***
// Checker for the accumulator execute slice.
// Sees only the top module's ports; attached by the bind below.
module acc_ops_checker (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR,
    input wire logic EXT_SET_EN,
    input wire logic [3:0] BANK_SELECT,
    input wire logic [11:0] INDEX_BASE,
    input wire logic [7:0] FILE_RDATA,
    input wire logic [11:0] FILE_ADDR,
    input wire acc_alu_pkg::file_wr_s FILE_WR,
    input wire logic [7:0] ACC,
    input wire acc_alu_pkg::flags_s FLAGS,
    input wire logic [1:0] PHASE,
    input wire logic INDEXED_MODE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    logic take;
    logic fop;
    // Instruction taken, and taken with a file operand
    assign take = PHASE == 2'h0 && INSTR_VALID;
    assign fop = take && INSTR[15:11] == 5'h04;
    sequence s_lit(logic [7:0] op);
        take && INSTR[15:8] == op;
    endsequence
    property p_take;
        take |=> PHASE == 2'h1;
    endproperty
    property p_phase_step;
        PHASE != 2'h0 |=> PHASE == $past(PHASE) + 2'h1;
    endproperty
    property p_add_lit;
        logic [7:0] k, w;
        (s_lit(acc_alu_pkg::OP_ADD_LIT), k = INSTR[7:0], w = ACC) |-> ##4
            ACC == 8'(w + k) && FLAGS.zero == (ACC == 8'h00)
            && FLAGS.negative == ACC[7];
    endproperty
    property p_and_lit;
        logic [7:0] k, w;
        acc_alu_pkg::flags_s f;
        (s_lit(acc_alu_pkg::OP_AND_LIT), k = INSTR[7:0], w = ACC, f = FLAGS)
            |-> ##4 ACC == (w & k) && FLAGS.carry == f.carry
            && FLAGS.half_carry_flag == f.half_carry_flag
            && FLAGS.signed_wrap_flag == f.signed_wrap_flag;
    endproperty
    property p_bank_addr;
        logic [11:0] a;
        (fop && INSTR[8], a = {BANK_SELECT, INSTR[7:0]}) |=> FILE_ADDR == a;
    endproperty
    property p_indexed;
        logic [11:0] a;
        (fop && !INSTR[8] && EXT_SET_EN && INSTR[7:0] <= 8'h5f,
            a = INDEX_BASE + 12'(INSTR[7:0])) |=> INDEXED_MODE && FILE_ADDR == a;
    endproperty
    property p_file_wr;
        logic [7:0] w, r;
        (fop && INSTR[10:9] == 2'b11, w = ACC) ##1 (1, r = FILE_RDATA) |-> ##3
            FILE_WR.we && FILE_WR.data == 8'(w + r) && ACC == w
            && FILE_WR.addr == FILE_ADDR;
    endproperty
    property p_no_wr;
        fop && !INSTR[9] |-> ##4 !FILE_WR.we;
    endproperty
    property p_carry_add;
        logic [7:0] w, r;
        logic c;
        (fop && INSTR[10:9] == 2'b00, w = ACC, c = FLAGS.carry)
            ##1 (1, r = FILE_RDATA) |-> ##3 ACC == 8'(w + r + 8'(c));
    endproperty
    a_take: assert property (p_take) else $error("no read phase");
    a_phase_step: assert property (p_phase_step)
        else $error("phase order broken");
    a_add_lit: assert property (p_add_lit)
        else $error("literal add wrong");
    a_and_lit: assert property (p_and_lit)
        else $error("literal and wrong");
    a_bank_addr: assert property (p_bank_addr)
        else $error("banked address wrong");
    a_indexed: assert property (p_indexed)
        else $error("indexed address wrong");
    a_file_wr: assert property (p_file_wr)
        else $error("file write wrong");
    a_no_wr: assert property (p_no_wr) else $error("stray write");
    a_carry_add: assert property (p_carry_add)
        else $error("carry add wrong");
endmodule

bind add_and_accumulator_ops acc_ops_checker chk (.SYS_CLK, .RESET_N,
    .INSTR_VALID, .INSTR, .EXT_SET_EN, .BANK_SELECT, .INDEX_BASE,
    .FILE_RDATA, .FILE_ADDR, .FILE_WR, .ACC, .FLAGS, .PHASE, .INDEXED_MODE);

// *** testbench/data_memory_model.sv ***
// Behavioural data memory facing the execute slice.
// Reads are combinational and valid in the read phase only.
module data_memory_model (
    input wire logic SYS_CLK,
    input wire logic [11:0] FILE_ADDR,
    input wire acc_alu_pkg::file_wr_s FILE_WR,
    input wire logic [1:0] PHASE,
    output logic [7:0] FILE_RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [4096];
    // Outside the read phase show the inverse, never stale data
    always_comb begin
        FILE_RDATA = mem[FILE_ADDR];
        if (PHASE != 2'h1) begin
            FILE_RDATA = ~FILE_RDATA;
        end
    end
    // Write port on the one-cycle strobe
    always @(posedge SYS_CLK) begin
        if (FILE_WR.we) begin
            mem[FILE_WR.addr] <= FILE_WR.data;
        end
    end
endmodule

// *** testbench/add_and_accumulator_ops_tb_top.sv ***
// Self-checking bench for the accumulator execute slice.
// One instruction at a time; the memory model answers operand reads.
module add_and_accumulator_ops_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK = 1'b0, RESET_N = 1'b0, INSTR_VALID = 1'b0;
    logic EXT_SET_EN = 1'b0, DONE, INDEXED_MODE;
    logic [15:0] INSTR = 16'h0000;
    logic [3:0] BANK_SELECT = 4'h0;
    logic [11:0] INDEX_BASE = 12'h200, FILE_ADDR;
    logic [7:0] FILE_RDATA, ACC;
    logic [1:0] PHASE;
    acc_alu_pkg::file_wr_s FILE_WR;
    acc_alu_pkg::flags_s FLAGS;
    int miscompares = 0;
    int n_compared = 0;
    always #10 SYS_CLK = ~SYS_CLK;
    add_and_accumulator_ops DUT (.SYS_CLK, .RESET_N, .INSTR_VALID, .INSTR,
        .EXT_SET_EN, .BANK_SELECT, .INDEX_BASE, .FILE_RDATA, .FILE_ADDR,
        .FILE_WR, .ACC, .FLAGS, .PHASE, .DONE, .INDEXED_MODE);
    data_memory_model mem_model (.SYS_CLK, .FILE_ADDR, .FILE_WR, .PHASE,
        .FILE_RDATA);
    // Compare and count
    task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Present one word, let it be taken, stop at its write edge
    task automatic run(logic [15:0] ins, logic ext, logic [3:0] bank);
        @(posedge SYS_CLK);
        INSTR <= ins;
        INSTR_VALID <= 1'b1;
        EXT_SET_EN <= ext;
        BANK_SELECT <= bank;
        @(posedge SYS_CLK);
        INSTR_VALID <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        #1;
        chk("done", 12'(DONE), 12'h001);
    endtask
    // Literal adds up to a wrap through zero
    task automatic t_add_lit;
        run(16'h0f10, 1'b0, 4'h0);
        run(16'h0f15, 1'b0, 4'h0);
        chk("acc", 12'(ACC), 12'h025);
        run(16'h0fdb, 1'b0, 4'h0);
        chk("acc", 12'(ACC), 12'h000);
        chk("flags", 12'(FLAGS), 12'h007);
        $display("t_add_lit done");
    endtask
    // Literal and keeps carry, half-carry and wrap
    task automatic t_and_lit;
        run(16'h0bff, 1'b0, 4'h0);
        chk("flags", 12'(FLAGS), 12'h007);
        run(16'h0fa3, 1'b0, 4'h0);
        chk("flags", 12'(FLAGS), 12'h010);
        run(16'h0b5f, 1'b0, 4'h0);
        chk("acc", 12'(ACC), 12'h003);
        $display("t_and_lit done");
    endtask
    // File add to the accumulator, then back to a banked register
    task automatic t_add_file;
        run(16'h0b00, 1'b0, 4'h0);
        run(16'h0f17, 1'b0, 4'h0);
        mem_model.mem[12'h005] = 8'hc2;
        run(16'h2405, 1'b0, 4'h0);
        chk("acc", 12'(ACC), 12'h0d9);
        chk("we", 12'(FILE_WR.we), 12'h000);
        chk("flags", 12'(FLAGS), 12'h010);
        mem_model.mem[12'h340] = 8'h80;
        run(16'h2740, 1'b0, 4'h3);
        chk("addr", FILE_WR.addr, 12'h340);
        chk("data", 12'(FILE_WR.data), 12'h059);
        chk("acc", 12'(ACC), 12'h0d9);
        chk("flags", 12'(FLAGS), 12'h009);
        $display("t_add_file done");
    endtask
    // Carry add through indexed mode, then a plain file add to the high access bank
    task automatic t_add_carry;
        mem_model.mem[12'h210] = 8'h02;
        run(16'h2010, 1'b1, 4'h0);
        chk("acc", 12'(ACC), 12'h0dc);
        chk("indexed", 12'(INDEXED_MODE), 12'h001);
        chk("flags", 12'(FLAGS), 12'h010);
        mem_model.mem[12'hf80] = 8'h30;
        run(16'h2680, 1'b1, 4'h0);
        chk("indexed", 12'(INDEXED_MODE), 12'h000);
        chk("addr", FILE_WR.addr, 12'hf80);
        chk("data", 12'(FILE_WR.data), 12'h00c);
        $display("t_add_carry done");
    endtask
    // Counts, verdict and end of run
    task automatic tally_and_finish;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        t_add_lit;
        t_and_lit;
        t_add_file;
        t_add_carry;
        tally_and_finish;
    end
    // Watchdog well past the roughly 65 cycles the tests need
    initial begin
        repeat (2000) @(posedge SYS_CLK);
        miscompares++;
        tally_and_finish;
    end
endmodule
